//--- lsbm_unit.sv
// Logic, shift/rotate and bit-manipulation execution stage.
// Assumes decoder supplies operands and current carry; result registered one cycle later.
`timescale 1ns/1ps
`include "lsbm_consts.svh"

// Contract
// - AND destination with source register or immediate, byte/word/longword.
// - OR destination with source register or immediate, byte/word/longword.
// - XOR destination with source register or immediate, byte/word/longword.
// - One's complement of a register at byte, word or longword size.
// - Arithmetic shift left and right of a register at any size.
// - Logical shift left and right of a register at any size.
// - Rotate left or right; leaving bit re-enters at other end.
// - Rotate left or right through the carry flag.
// - Bit number from 3-bit immediate or low three source register bits.
// - Bit set forces selected byte bit to one.
// - Bit clear forces selected byte bit to zero.
// - Bit invert toggles selected byte bit and writes byte back.
// - Bit test loads zero flag with complement of selected bit.
// - Carry becomes carry AND selected bit.
// - Carry becomes carry AND inverted selected bit.
// - Carry becomes carry OR selected bit.
// - Carry becomes carry OR inverted selected bit.
// - Carry becomes carry XOR selected bit.
// - Carry becomes carry XOR inverted selected bit.
// - Bit load copies selected bit, or complement, into carry.
// - Bit store writes carry, or complement, into selected bit.
// - Inverted bit operations take bit number only from immediate.
module lsbm_unit (
  input wire logic i_clk,                        // Core clock, 250 MHz
  input wire logic i_reset_n,                    // Asynchronous reset, active low
  input wire logic i_valid,                      // Request valid this cycle
  input wire lsbm_pkg::lsbm_req_s i_req,         // Operation and operands
  input wire logic i_carry,                      // Current carry flag
  output logic o_valid,                          // Answer valid, one-cycle pulse
  output lsbm_pkg::lsbm_rsp_s o_rsp              // Registered answer
);

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  logic [`LSBM_DATA_W-1:0] opnd_b;
  logic [`LSBM_BITNO_W-1:0] bitno;
  logic inv_op;
  logic is_bit_op;

  // Second operand for logical group
  assign opnd_b = i_req.use_imm ? i_req.imm : i_req.src;

  // Bit number source; inverted forms force the immediate field
  always_comb begin
    inv_op = 1'b0;
    unique case (i_req.op)
      lsbm_pkg::LSBM_OP_CARRY_AND_INVERTED_BIT,
      lsbm_pkg::LSBM_OP_CARRY_OR_INVERTED_BIT,
      lsbm_pkg::LSBM_OP_CARRY_XOR_INVERTED_BIT,
      lsbm_pkg::LSBM_OP_INVERTED_BIT_LOAD_TO_CARRY,
      lsbm_pkg::LSBM_OP_INVERTED_CARRY_STORE_TO_BIT: inv_op = 1'b1;
      default: inv_op = 1'b0;
    endcase
  end

  assign is_bit_op = (i_req.op >= lsbm_pkg::LSBM_OP_BIT_SET);
  assign bitno = (i_req.use_imm || inv_op) ? i_req.imm_bitno
                                           : i_req.src[`LSBM_BITNO_W-1:0];

  // ----------------------------------------------------------------
  // Size-dependent sign and carry-out positions
  // ----------------------------------------------------------------
  logic [5:0] msb;

  always_comb begin
    unique case (i_req.size)
      lsbm_pkg::LSBM_SZ_BYTE: msb = 6'(`LSBM_BYTE_MSB);
      lsbm_pkg::LSBM_SZ_WORD: msb = 6'(`LSBM_WORD_MSB);
      default: msb = 6'(`LSBM_LONG_MSB);
    endcase
  end

  // ----------------------------------------------------------------
  // Logical, shift and rotate datapath
  // ----------------------------------------------------------------
  logic [`LSBM_DATA_W-1:0] d;
  logic [`LSBM_DATA_W-1:0] shl;
  logic [`LSBM_DATA_W-1:0] shr;
  logic top;
  logic bot;
  logic [`LSBM_DATA_W-1:0] wide;
  logic new_c;
  logic c_we;
  logic v_val;
  logic is_wide_op;

  assign d = i_req.dst;
  assign top = d[msb[4:0]];
  assign bot = d[0];
  assign shl = d << 1;
  assign shr = d >> 1;

  // Result before masking to operand width
  always_comb begin
    wide = d;
    new_c = i_carry;
    c_we = 1'b0;
    v_val = 1'b0;
    is_wide_op = 1'b1;
    unique case (i_req.op)
      lsbm_pkg::LSBM_OP_AND: wide = d & opnd_b;
      lsbm_pkg::LSBM_OP_OR: wide = d | opnd_b;
      lsbm_pkg::LSBM_OP_XOR: wide = d ^ opnd_b;
      lsbm_pkg::LSBM_OP_NOT: wide = ~d;
      lsbm_pkg::LSBM_OP_ARITH_SHIFT_LEFT: begin
        wide = shl;
        new_c = top;
        c_we = 1'b1;
        v_val = top ^ d[msb[4:0] - 5'd1];               // Sign changed by shift
      end
      lsbm_pkg::LSBM_OP_ARITH_SHIFT_RIGHT: begin
        wide = shr;
        wide[msb[4:0]] = top;                           // Sign kept
        new_c = bot;
        c_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_LOGIC_SHIFT_LEFT: begin
        wide = shl;
        new_c = top;
        c_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_LOGIC_SHIFT_RIGHT: begin
        wide = shr;
        wide[msb[4:0]] = 1'b0;
        new_c = bot;
        c_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_ROTATE_LEFT: begin
        wide = {shl[`LSBM_DATA_W-1:1], top};
        new_c = top;
        c_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_ROTATE_RIGHT: begin
        wide = shr;
        wide[msb[4:0]] = bot;
        new_c = bot;
        c_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_ROTATE_LEFT_VIA_CARRY: begin
        wide = {shl[`LSBM_DATA_W-1:1], i_carry};
        new_c = top;
        c_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_ROTATE_RIGHT_VIA_CARRY: begin
        wide = shr;
        wide[msb[4:0]] = i_carry;
        new_c = bot;
        c_we = 1'b1;
      end
      default: is_wide_op = 1'b0;
    endcase
  end

  // Keep untouched upper bits of the destination register
  logic [`LSBM_DATA_W-1:0] size_mask;
  logic [`LSBM_DATA_W-1:0] wide_res;
  logic wide_n;
  logic wide_z;

  always_comb begin
    unique case (i_req.size)
      lsbm_pkg::LSBM_SZ_BYTE: size_mask = 32'h000000FF;
      lsbm_pkg::LSBM_SZ_WORD: size_mask = 32'h0000FFFF;
      default: size_mask = 32'hFFFFFFFF;
    endcase
  end

  assign wide_res = (wide & size_mask) | (d & ~size_mask);
  assign wide_n = wide[msb[4:0]];
  assign wide_z = ((wide & size_mask) == 32'h00000000);

  // ----------------------------------------------------------------
  // Bit-manipulation group
  // ----------------------------------------------------------------
  logic [`LSBM_BYTE_MSB:0] bit_byte;
  logic bit_write;
  logic bit_carry;
  logic bit_carry_we;
  logic bit_zero;
  logic bit_zero_we;

  lsbm_bit_unit u_bit (
    .i_op(i_req.op),
    .i_byte(d[`LSBM_BYTE_MSB:0]),
    .i_bitno(bitno),
    .i_carry(i_carry),
    .o_byte(bit_byte),
    .o_write(bit_write),
    .o_carry(bit_carry),
    .o_carry_we(bit_carry_we),
    .o_zero(bit_zero),
    .o_zero_we(bit_zero_we)
  );

  // ----------------------------------------------------------------
  // Answer assembly
  // ----------------------------------------------------------------
  lsbm_pkg::lsbm_rsp_s rsp_next;

  // Bit ops touch only the low byte; register bit number on inverted forms is flagged
  always_comb begin
    rsp_next = '0;
    if (is_wide_op) begin
      rsp_next.result = wide_res;
      rsp_next.write_dst = 1'b1;
      rsp_next.flags.n = wide_n;
      rsp_next.flags.z = wide_z;
      rsp_next.flags.v = v_val;
      rsp_next.flags.c = new_c;
      rsp_next.flag_we = {3'b111, c_we};
    end else if (is_bit_op) begin
      rsp_next.result = {d[`LSBM_DATA_W-1:`LSBM_BYTE_MSB+1], bit_byte};
      rsp_next.write_dst = bit_write;
      rsp_next.flags.z = bit_zero;
      rsp_next.flags.c = bit_carry;
      rsp_next.flag_we = {1'b0, bit_zero_we, 1'b0, bit_carry_we};
      rsp_next.illegal = inv_op & ~i_req.use_imm;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Answer valid pulse follows each request by exactly one cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_valid <= 1'b0;
    end else begin
      o_valid <= i_valid;
    end
  end

  // Answer held until the next request, so the stage may sample late
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rsp <= '0;
    end else if (i_valid) begin
      o_rsp <= rsp_next;
    end
  end

endmodule // lsbm_unit

//--- lsbm_consts.svh
// Constants for the logic, shift and bit-manipulation unit.
// Assumes inclusion by the package and both design modules.
`ifndef LSBM_CONSTS_SVH
`define LSBM_CONSTS_SVH

// ----------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------
`define LSBM_DATA_W 32
`define LSBM_BYTE_MSB 7
`define LSBM_WORD_MSB 15
`define LSBM_LONG_MSB 31
`define LSBM_BITNO_W 3
`define LSBM_RESULT_RST 32'h00000000

`endif

//--- lsbm_pkg.sv
// Types shared by the logic, shift and bit-manipulation unit.
// Assumes lsbm_consts.svh is on the include path.
`include "lsbm_consts.svh"

package lsbm_pkg;

  // ----------------------------------------------------------------
  // Operand size and operation codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LSBM_SZ_BYTE,
    LSBM_SZ_WORD,
    LSBM_SZ_LONG
  } lsbm_size_e;

  typedef enum logic [5:0] {
    LSBM_OP_AND,
    LSBM_OP_OR,
    LSBM_OP_XOR,
    LSBM_OP_NOT,
    LSBM_OP_ARITH_SHIFT_LEFT,
    LSBM_OP_ARITH_SHIFT_RIGHT,
    LSBM_OP_LOGIC_SHIFT_LEFT,
    LSBM_OP_LOGIC_SHIFT_RIGHT,
    LSBM_OP_ROTATE_LEFT,
    LSBM_OP_ROTATE_RIGHT,
    LSBM_OP_ROTATE_LEFT_VIA_CARRY,
    LSBM_OP_ROTATE_RIGHT_VIA_CARRY,
    LSBM_OP_BIT_SET,
    LSBM_OP_BIT_CLEAR,
    LSBM_OP_BIT_INVERT,
    LSBM_OP_BIT_TEST,
    LSBM_OP_CARRY_AND_BIT,
    LSBM_OP_CARRY_AND_INVERTED_BIT,
    LSBM_OP_CARRY_OR_BIT,
    LSBM_OP_CARRY_OR_INVERTED_BIT,
    LSBM_OP_CARRY_XOR_BIT,
    LSBM_OP_CARRY_XOR_INVERTED_BIT,
    LSBM_OP_BIT_LOAD_TO_CARRY,
    LSBM_OP_INVERTED_BIT_LOAD_TO_CARRY,
    LSBM_OP_CARRY_STORE_TO_BIT,
    LSBM_OP_INVERTED_CARRY_STORE_TO_BIT
  } lsbm_op_e;

  // Request from the decoder
  typedef struct packed {
    lsbm_op_e op;
    lsbm_size_e size;
    logic use_imm;                          // Second operand / bit number is immediate
    logic [`LSBM_DATA_W-1:0] dst;           // Destination register or memory byte
    logic [`LSBM_DATA_W-1:0] src;           // Source register value
    logic [`LSBM_DATA_W-1:0] imm;           // Immediate data
    logic [`LSBM_BITNO_W-1:0] imm_bitno;    // 3-bit immediate bit number
  } lsbm_req_s;

  // Condition flags
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } lsbm_flags_s;

  // Answer to the register file and memory stage
  typedef struct packed {
    logic [`LSBM_DATA_W-1:0] result;
    logic write_dst;                        // Result must be written back
    lsbm_flags_s flags;
    logic [3:0] flag_we;                    // Write enables for n, z, v, c
    logic illegal;                          // Register bit number where only immediate allowed
  } lsbm_rsp_s;

endpackage : lsbm_pkg

//--- lsbm_bit_unit.sv
// Single-bit manipulation on a byte operand and carry-flag logic.
// Assumes a combinational caller in the same clock domain.
`timescale 1ns/1ps
`include "lsbm_consts.svh"

module lsbm_bit_unit (
  input wire lsbm_pkg::lsbm_op_e i_op,                   // Operation
  input wire logic [`LSBM_BYTE_MSB:0] i_byte,            // Byte operand
  input wire logic [`LSBM_BITNO_W-1:0] i_bitno,          // Selected bit number
  input wire logic i_carry,                              // Current carry flag
  output logic [`LSBM_BYTE_MSB:0] o_byte,                // Modified byte
  output logic o_write,                                  // Byte must be written back
  output logic o_carry,                                  // New carry flag
  output logic o_carry_we,                               // Carry updated
  output logic o_zero,                                   // New zero flag
  output logic o_zero_we                                 // Zero updated
);

  // ----------------------------------------------------------------
  // Selected bit and one-hot mask
  // ----------------------------------------------------------------
  logic sel_bit;
  logic [`LSBM_BYTE_MSB:0] mask;

  assign sel_bit = i_byte[i_bitno];
  assign mask = 8'h01 << i_bitno;

  // Per-operation effect on byte and flags
  always_comb begin
    o_byte = i_byte;
    o_write = 1'b0;
    o_carry = i_carry;
    o_carry_we = 1'b0;
    o_zero = 1'b0;
    o_zero_we = 1'b0;
    unique case (i_op)
      lsbm_pkg::LSBM_OP_BIT_SET: begin
        o_byte = i_byte | mask;
        o_write = 1'b1;
      end
      lsbm_pkg::LSBM_OP_BIT_CLEAR: begin
        o_byte = i_byte & ~mask;
        o_write = 1'b1;
      end
      lsbm_pkg::LSBM_OP_BIT_INVERT: begin
        o_byte = i_byte ^ mask;
        o_write = 1'b1;
      end
      lsbm_pkg::LSBM_OP_BIT_TEST: begin
        o_zero = ~sel_bit;
        o_zero_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_CARRY_AND_BIT: begin
        o_carry = i_carry & sel_bit;
        o_carry_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_CARRY_AND_INVERTED_BIT: begin
        o_carry = i_carry & ~sel_bit;
        o_carry_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_CARRY_OR_BIT: begin
        o_carry = i_carry | sel_bit;
        o_carry_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_CARRY_OR_INVERTED_BIT: begin
        o_carry = i_carry | ~sel_bit;
        o_carry_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_CARRY_XOR_BIT: begin
        o_carry = i_carry ^ sel_bit;
        o_carry_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_CARRY_XOR_INVERTED_BIT: begin
        o_carry = i_carry ^ ~sel_bit;
        o_carry_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_BIT_LOAD_TO_CARRY: begin
        o_carry = sel_bit;
        o_carry_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_INVERTED_BIT_LOAD_TO_CARRY: begin
        o_carry = ~sel_bit;
        o_carry_we = 1'b1;
      end
      lsbm_pkg::LSBM_OP_CARRY_STORE_TO_BIT: begin
        o_byte = i_carry ? (i_byte | mask) : (i_byte & ~mask);
        o_write = 1'b1;
      end
      lsbm_pkg::LSBM_OP_INVERTED_CARRY_STORE_TO_BIT: begin
        o_byte = i_carry ? (i_byte & ~mask) : (i_byte | mask);
        o_write = 1'b1;
      end
      default: begin
      end
    endcase
  end

endmodule // lsbm_bit_unit

//--- lsbm_unit_props.sv
// Assertions for the logic, shift and bit-manipulation unit.
// Assumes binding to lsbm_unit; sees its ports only.
`timescale 1ns/1ps

module lsbm_unit_props (
  input wire logic i_clk,                 // Core clock
  input wire logic i_reset_n,             // Async reset, active low
  input wire logic i_valid,               // Request valid
  input wire lsbm_pkg::lsbm_req_s i_req,  // Request
  input wire logic i_carry,               // Carry in
  input wire logic o_valid,               // Answer valid
  input wire lsbm_pkg::lsbm_rsp_s o_rsp   // Answer
);
  // ----------------------------------------------------------------
  // Helper terms
  // ----------------------------------------------------------------
  logic [2:0] bn;
  logic sel;
  logic [31:0] opb;
  logic lng;
  // Bit number and operand as a legal request would pick them
  assign bn = i_req.use_imm ? i_req.imm_bitno : i_req.src[2:0];
  assign sel = i_req.dst[bn];
  assign opb = i_req.use_imm ? i_req.imm : i_req.src;
  assign lng = i_valid && i_req.size == lsbm_pkg::LSBM_SZ_LONG;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_answer_latency: assert property (i_valid |=> o_valid)
    else $error("answer missing");
  a_no_spurious: assert property (!i_valid |=> !o_valid)
    else $error("answer without request");
  a_and_long: assert property (lng && i_req.op == lsbm_pkg::LSBM_OP_AND |=>
    o_rsp.result == $past(i_req.dst & opb)) else $error("and result wrong");
  a_not_long: assert property (lng && i_req.op == lsbm_pkg::LSBM_OP_NOT |=>
    o_rsp.result == ~$past(i_req.dst)) else $error("complement wrong");
  a_bit_set: assert property (i_valid && i_req.op == lsbm_pkg::LSBM_OP_BIT_SET |=>
    o_rsp.result[7:0] == $past(i_req.dst[7:0] | (8'h01 << bn))) else $error("set wrong");
  a_bit_test: assert property (i_valid && i_req.op == lsbm_pkg::LSBM_OP_BIT_TEST |=>
    o_rsp.flags.z == !$past(sel) && o_rsp.flag_we == 4'h4) else $error("test wrong");
  a_carry_and: assert property (i_valid && i_req.op == lsbm_pkg::LSBM_OP_CARRY_AND_BIT |=>
    o_rsp.flags.c == $past(i_carry & sel)) else $error("carry and wrong");
  a_logic_flags: assert property (i_valid && i_req.op <= lsbm_pkg::LSBM_OP_NOT |=>
    !o_rsp.flags.v && o_rsp.flag_we == 4'hE) else $error("logic flags wrong");
  a_inv_regno: assert property (i_valid && !i_req.use_imm &&
    i_req.op == lsbm_pkg::LSBM_OP_CARRY_AND_INVERTED_BIT |=> o_rsp.illegal)
    else $error("illegal not flagged");
endmodule // lsbm_unit_props

bind lsbm_unit lsbm_unit_props lsbm_unit_props_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_valid(i_valid), .i_req(i_req), .i_carry(i_carry), .o_valid(o_valid), .o_rsp(o_rsp));

//--- lsbm_core_model.sv
// Core-side model: the carry flag as the register file keeps it.
// Assumes one clock with the unit; the bench may override the carry.
`timescale 1ns/1ps

module lsbm_core_model (
  input wire logic i_clk,                // Core clock
  input wire logic i_reset_n,            // Async reset, active low
  input wire logic i_force,              // Bench overrides carry
  input wire logic i_force_c,            // Override value
  input wire logic i_valid,              // Unit answer valid
  input wire lsbm_pkg::lsbm_rsp_s i_rsp, // Unit answer
  output logic o_carry                   // Carry to the unit
);
  logic carry_reg;
  // Carry follows the unit only when its write enable says so
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      carry_reg <= 1'b0;
    end else if (i_valid && i_rsp.flag_we[0]) begin
      carry_reg <= i_rsp.flags.c;
    end
  end
  // Override is combinational so a request sees it at once
  assign o_carry = i_force ? i_force_c : carry_reg;
endmodule // lsbm_core_model

//--- testbench.sv
// Self-checking bench for the logic, shift and bit-manipulation unit.
// Assumes the package, the unit and the core model are compiled first.
`timescale 1ns/1ps
`include "lsbm_consts.svh"

module testbench;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_valid = 1'b0;
  lsbm_pkg::lsbm_req_s req = '0;
  logic frc = 1'b0;
  logic frc_c = 1'b0;
  logic carry;
  logic o_valid;
  lsbm_pkg::lsbm_rsp_s rsp;
  int fail_count = 0;
  int n_compared = 0;

  // ----------------------------------------------------------------
  // Clock and instances
  // ----------------------------------------------------------------
  // 250 MHz core clock
  always #2 i_clk = ~i_clk;
  lsbm_unit lsbm_unit_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_valid(i_valid),
    .i_req(req), .i_carry(carry), .o_valid(o_valid), .o_rsp(rsp));
  lsbm_core_model lsbm_core_model_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_force(frc),
    .i_force_c(frc_c), .i_valid(o_valid), .i_rsp(rsp), .o_carry(carry));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic int msb(input int k);
    return k == 0 ? `LSBM_BYTE_MSB : k == 1 ? `LSBM_WORD_MSB : `LSBM_LONG_MSB;
  endfunction
  function automatic logic [31:0] mk(input int m);
    return m == 31 ? 32'hFFFF_FFFF : (32'h1 << (m + 1)) - 32'h1;
  endfunction
  function automatic logic [1:0] nz(input logic [31:0] r, input int m);
    return {r[m], (r & mk(m)) == 32'h0};
  endfunction
  // Single-bit shift or rotate with top bit m; returns carry out and result
  function automatic logic [32:0] sh(input int k, input int m, input logic [31:0] d, c);
    logic [31:0] x;
    logic [31:0] r;
    x = d & mk(m);
    case (k)
      0, 2: r = x << 1;
      1: r = (x >> 1) | (32'(x[m]) << m);
      3: r = x >> 1;
      4: r = (x << 1) | 32'(x[m]);
      5: r = (x >> 1) | (32'(x[0]) << m);
      6: r = (x << 1) | 32'(c);
      default: r = (x >> 1) | (32'(c) << m);
    endcase
    return {(k % 2 == 0) ? x[m] : x[0], (d & ~mk(m)) | (r & mk(m))};
  endfunction
  // One request held for one edge; answer checked in the following cycle
  task automatic issue(input lsbm_pkg::lsbm_op_e op, input int k, input logic ui,
                       input logic [31:0] d, s, im, input logic [2:0] bn, input logic f, c);
    @(posedge i_clk);
    #1;
    req = '{op, lsbm_pkg::lsbm_size_e'(k), ui, d, s, im, bn};
    i_valid = 1'b1;
    frc = f;
    frc_c = c;
    @(posedge i_clk);
    #1;
    i_valid = 1'b0;
    frc = 1'b0;
    check(o_valid, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_logic;
    lsbm_pkg::lsbm_op_e op;
    logic [31:0] r;
    logic [31:0] e;
    logic ui;
    for (int k = 0; k < 3; k++) begin
      op = lsbm_pkg::LSBM_OP_AND;
      for (int o = 0; o < 4; o++) begin
        ui = o[0] ^ k[0];
        r = ui ? 32'h0FF0_0FF0 : 32'hF0F0_F00F;
        r = o == 0 ? 32'hC3A5_8F0F & r : o == 1 ? 32'hC3A5_8F0F | r
          : o == 2 ? 32'hC3A5_8F0F ^ r : ~32'hC3A5_8F0F;
        e = (32'hC3A5_8F0F & ~mk(msb(k))) | (r & mk(msb(k)));
        issue(op, k, ui, 32'hC3A5_8F0F, 32'hF0F0_F00F, 32'h0FF0_0FF0, 3'h0, 1'b1, 1'b1);
        check(rsp.result, e);
        check({rsp.flags.n, rsp.flags.z, rsp.flags.v, rsp.flag_we, rsp.write_dst},
              {nz(e, msb(k)), 1'b0, 4'hE, 1'b1});
        op = op.next();
      end
    end
    // Zero result at byte width with upper bits set
    issue(lsbm_pkg::LSBM_OP_AND, 0, 1'b1, 32'hFFFF_FF80, 32'h0, 32'h7F, 3'h0, 1'b0, 1'b0);
    check({rsp.result, rsp.flags.n, rsp.flags.z}, {32'hFFFF_FF00, 2'h1});
  endtask

  task automatic t_shift;
    lsbm_pkg::lsbm_op_e op;
    logic [32:0] e;
    for (int k = 0; k < 3; k++) begin
      op = lsbm_pkg::LSBM_OP_ARITH_SHIFT_LEFT;
      for (int o = 0; o < 8; o++) begin
        e = sh(o, msb(k), 32'h4A5C_81C3, o[1]);
        issue(op, k, 1'b0, 32'h4A5C_81C3, 32'h0, 32'h0, 3'h0, 1'b1, o[1]);
        check({rsp.flags.c, rsp.result}, e);
        check({rsp.flags.n, rsp.flags.z, rsp.flag_we, rsp.write_dst},
              {nz(e[31:0], msb(k)), 4'hF, 1'b1});
        check(rsp.flags.v, o == 0 ? e[msb(k)] ^ e[32] : 1'b0);
        op = op.next();
      end
    end
    // Carry from the first rotate feeds the second through the core
    issue(lsbm_pkg::LSBM_OP_ROTATE_LEFT_VIA_CARRY, 0, 1'b0, 32'h80, 32'h0, 32'h0, 3'h0,
          1'b1, 1'b0);
    issue(lsbm_pkg::LSBM_OP_ROTATE_LEFT_VIA_CARRY, 0, 1'b0, 32'h01, 32'h0, 32'h0, 3'h0,
          1'b0, 1'b0);
    check(rsp.result, 32'h03);
  endtask

  task automatic t_bit;
    lsbm_pkg::lsbm_op_e op;
    logic [7:0] m;
    logic ui;
    for (int b = 0; b < 8; b++) begin
      op = lsbm_pkg::LSBM_OP_BIT_SET;
      m = 8'h01 << b;
      for (int o = 0; o < 4; o++) begin
        ui = o[0] ^ b[0];
        // Unused bit-number source holds a different value
        issue(op, 0, ui, 32'hA5A5_5A3C, ui ? 32'(b ^ 5) : 32'(b), 32'h0,
              ui ? 3'(b) : 3'(b ^ 5), 1'b1, 1'b0);
        if (o == 3) begin
          check({rsp.flags.z, rsp.flag_we, rsp.write_dst},
                {(8'h3C & m) == 8'h00, 4'h4, 1'b0});
        end else begin
          check(rsp.result, {24'hA5A55A, o == 0 ? 8'h3C | m : o == 1 ? 8'h3C & ~m
                : 8'h3C ^ m});
        end
        op = op.next();
      end
    end
  endtask

  task automatic t_carry;
    lsbm_pkg::lsbm_op_e op;
    logic x;
    logic e;
    op = lsbm_pkg::LSBM_OP_CARRY_AND_BIT;
    for (int o = 0; o < 8; o++) begin
      for (int v = 0; v < 4; v++) begin
        x = v[1] ^ o[0];
        e = o / 2 == 0 ? v[0] & x : o / 2 == 1 ? v[0] | x : o / 2 == 2 ? v[0] ^ x : x;
        // Bit five carries the operand; bit two holds its inverse
        issue(op, 0, o[0] | v[0], v[1] ? 32'h20 : 32'h04, 32'h5, 32'h0, 3'h5, 1'b1, v[0]);
        check({rsp.flags.c, rsp.flag_we, rsp.illegal, rsp.write_dst},
              {e, 4'h1, 2'h0});
      end
      op = op.next();
    end
  endtask

  task automatic t_store;
    for (int b = 0; b < 8; b++) begin
      issue(lsbm_pkg::LSBM_OP_CARRY_STORE_TO_BIT, 0, 1'b1, 32'h1234_5655, 32'h0, 32'h0,
            3'(b), 1'b1, b[0]);
      check(rsp.result, {24'h123456, (8'h55 & ~(8'h01 << b)) | (8'(b[0]) << b)});
      issue(lsbm_pkg::LSBM_OP_INVERTED_CARRY_STORE_TO_BIT, 0, 1'b1, 32'h1234_5655, 32'h0,
            32'h0, 3'(b), 1'b1, b[0]);
      check(rsp.result, {24'h123456, (8'h55 & ~(8'h01 << b)) | (8'(!b[0]) << b)});
    end
  endtask

  task automatic t_illegal;
    // Register bit number is refused in form but immediate still used
    issue(lsbm_pkg::LSBM_OP_CARRY_AND_INVERTED_BIT, 0, 1'b0, 32'h20, 32'h5, 32'h0, 3'h2,
          1'b1, 1'b1);
    check({rsp.flags.c, rsp.illegal}, 2'h3);
    issue(lsbm_pkg::LSBM_OP_INVERTED_CARRY_STORE_TO_BIT, 0, 1'b0, 32'h0, 32'h5, 32'h0, 3'h2,
          1'b1, 1'b0);
    check({rsp.result, rsp.illegal}, {32'h04, 1'b1});
  endtask

  task automatic t_b2b;
    @(posedge i_clk);
    #1;
    req = '{lsbm_pkg::LSBM_OP_OR, lsbm_pkg::LSBM_SZ_LONG, 1'b0, 32'h1200_0034, 32'h0056_7800,
            32'h0, 3'h0};
    i_valid = 1'b1;
    @(posedge i_clk);
    #1;
    req.op = lsbm_pkg::LSBM_OP_XOR;
    req.size = lsbm_pkg::LSBM_SZ_WORD;
    check({o_valid, rsp.result}, {1'b1, 32'h1256_7834});
    @(posedge i_clk);
    #1;
    i_valid = 1'b0;
    check({o_valid, rsp.result}, {1'b1, 32'h1200_7834});
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    t_logic();
    t_shift();
    t_bit();
    t_carry();
    t_store();
    t_illegal();
    t_b2b();
    results();
  end
  // Whole run needs under a thousand cycles; the limit leaves ample margin
  initial begin
    #(20000 * 4);
    fail_count++;
    results();
  end
endmodule // testbench
